// file: core/startup_config_protect_regs.sv
// startup configuration, memory map position and option registers with write protection
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`include "startup_cfg_consts.svh"

module startup_config_protect_regs #(
  parameter int PRESCALE_LOG2 = `SCP_WDOG_PRESCALE_LOG2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // mode pins and reset sources
  input wire logic mode_pin_a,
  input wire logic mode_pin_b,
  input wire logic ext_reset_n,
  input wire logic watchdog_timeout,
  input wire logic clock_monitor_fail,
  // cpu side
  output logic core_reset,
  output startup_cfg_pkg::reset_vector_t reset_vector,
  input wire logic stop_wake,
  output logic stop_resume,
  // memory decode
  input wire logic [15:0] cpu_addr,
  output logic sel_regs,
  output logic sel_ram,
  output logic sel_rom,
  // configuration to the rest of the chip
  output startup_cfg_pkg::config_t cfg_out,
  output startup_cfg_pkg::options_t opt_out,
  output logic watchdog_tick
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic page_is(input logic [15:0] a, input logic [3:0] page);
    page_is = (a[15:12] == page);
  endfunction

  localparam int WDW = PRESCALE_LOG2 + 6;

  function automatic logic [WDW-1:0] rate_mask(input logic [1:0] rate);
    logic [WDW-1:0] m;
    m = '0;
    for (int i = 0; i < WDW; i++)
    begin
      if (i < PRESCALE_LOG2 + 2 * int'(rate))
      begin
        m[i] = 1'b1;
      end
    end
    rate_mask = m;
  endfunction

  // ---------------------------------------------------------------
  // reset sequencing
  // ---------------------------------------------------------------
  startup_cfg_pkg::reset_state_t rst_state_q;
  logic [11:0] rst_cnt_q;
  logic in_reset;
  logic special_q;
  logic expanded_q;
  startup_cfg_pkg::config_t cfg_q;
  startup_cfg_pkg::options_t opt_q;

  assign in_reset = (rst_state_q != startup_cfg_pkg::RST_RUN);

  // power-on delay, then pin wait; internal sources take a short reset
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_state_q <= startup_cfg_pkg::RST_POWER_ON;
      rst_cnt_q <= 12'h000;
    end
    else
    begin
      case (rst_state_q)
        startup_cfg_pkg::RST_POWER_ON:
        begin
          if (rst_cnt_q == `SCP_POR_DELAY - 12'h001)
          begin
            rst_state_q <= startup_cfg_pkg::RST_PIN_WAIT;
            rst_cnt_q <= 12'h000;
          end
          else
          begin
            rst_cnt_q <= rst_cnt_q + 12'h001;
          end
        end
        startup_cfg_pkg::RST_INTERNAL:
        begin
          if (rst_cnt_q == {9'h000, `SCP_INT_RESET_LEN} - 12'h001)
          begin
            rst_state_q <= startup_cfg_pkg::RST_PIN_WAIT;
            rst_cnt_q <= 12'h000;
          end
          else
          begin
            rst_cnt_q <= rst_cnt_q + 12'h001;
          end
        end
        startup_cfg_pkg::RST_PIN_WAIT:
        begin
          if (ext_reset_n)
          begin
            rst_state_q <= startup_cfg_pkg::RST_RUN;
          end
        end
        default:
        begin
          rst_cnt_q <= 12'h000;
          if (!ext_reset_n)
          begin
            rst_state_q <= startup_cfg_pkg::RST_PIN_WAIT;
          end
          else if ((watchdog_timeout && !cfg_q.watchdog_disable)
            || (clock_monitor_fail && opt_q.clock_monitor_enable))
          begin
            rst_state_q <= startup_cfg_pkg::RST_INTERNAL;
          end
        end
      endcase
    end
  end

  // vector: pin wins over internal sources, as the pin means an outside reset
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reset_vector <= startup_cfg_pkg::VEC_NORMAL;
    end
    else if (rst_state_q == startup_cfg_pkg::RST_RUN)
    begin
      if (!ext_reset_n)
      begin
        reset_vector <= startup_cfg_pkg::VEC_NORMAL;
      end
      else if (watchdog_timeout && !cfg_q.watchdog_disable)
      begin
        reset_vector <= startup_cfg_pkg::VEC_WATCHDOG;
      end
      else if (clock_monitor_fail && opt_q.clock_monitor_enable)
      begin
        reset_vector <= startup_cfg_pkg::VEC_CLOCK_MONITOR;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      core_reset <= 1'b1;
    end
    else
    begin
      core_reset <= in_reset;
    end
  end

  // ---------------------------------------------------------------
  // write protection window
  // ---------------------------------------------------------------
  logic [6:0] win_cnt_q;
  logic win_open;
  logic wr_cfg_q;
  logic wr_opt_q;
  logic wr_map_q;
  logic [7:0] map_q;

  assign win_open = (win_cnt_q != `SCP_PROTECT_WINDOW);

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      win_cnt_q <= 7'h00;
    end
    else if (in_reset)
    begin
      win_cnt_q <= 7'h00;
    end
    else if (win_open)
    begin
      win_cnt_q <= win_cnt_q + 7'h01;
    end
  end

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  logic req;
  logic wr;
  logic [5:0] idx;
  logic prot_ok;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx = wb_adr_i[7:2];
  assign wr = req && wb_we_i && wb_sel_i[0] && !in_reset;
  assign prot_ok = special_q || win_open;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wb_dat_o <= 32'h00000000;
    end
    else if (req && !wb_we_i)
    begin
      if (idx == `SCP_IDX_SYSTEM_OPTIONS)
      begin
        wb_dat_o <= {26'h0000000, opt_q.irq_edge_select, opt_q.stop_exit_delay_enable,
          opt_q.clock_monitor_enable, 1'b0, opt_q.watchdog_rate_select};
      end
      else if (idx == `SCP_IDX_STARTUP_CONFIG)
      begin
        wb_dat_o <= {29'h00000000, cfg_q.watchdog_disable, cfg_q.rom_enable, 1'b0};
      end
      else if (idx == `SCP_IDX_MAP_POSITION)
      begin
        wb_dat_o <= {24'h000000, map_q};
      end
      else if (idx == `SCP_IDX_MODE_STATUS)
      begin
        wb_dat_o <= {24'h000000, reset_vector, wr_map_q, wr_opt_q, wr_cfg_q, win_open,
          expanded_q, special_q};
      end
      else
      begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

  // ---------------------------------------------------------------
  // mode latch
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      special_q <= 1'b0;
      expanded_q <= 1'b0;
    end
    else if (in_reset)
    begin
      special_q <= !mode_pin_b;
      expanded_q <= mode_pin_a && mode_pin_b;
    end
    else if (wr && idx == `SCP_IDX_MODE_STATUS && !wb_dat_i[0])
    begin
      special_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // startup configuration latch
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_q <= '{watchdog_disable: 1'b0, rom_enable: 1'b1};
      wr_cfg_q <= 1'b0;
    end
    else if (in_reset)
    begin
      cfg_q.watchdog_disable <= !mode_pin_b;
      cfg_q.rom_enable <= 1'b1;
      wr_cfg_q <= 1'b0;
    end
    else if (wr && idx == `SCP_IDX_STARTUP_CONFIG && prot_ok
      && (special_q || !wr_cfg_q))
    begin
      cfg_q.watchdog_disable <= wb_dat_i[`SCP_CFG_WDOG_DIS];
      cfg_q.rom_enable <= wb_dat_i[`SCP_CFG_ROM_EN];
      wr_cfg_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // system options
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      opt_q <= 5'(`SCP_RST_SYSTEM_OPTIONS >> 1);
      wr_opt_q <= 1'b0;
    end
    else if (in_reset)
    begin
      opt_q.irq_edge_select <= 1'b0;
      opt_q.stop_exit_delay_enable <= 1'b1;
      opt_q.clock_monitor_enable <= 1'b0;
      opt_q.watchdog_rate_select <= 2'b00;
      wr_opt_q <= 1'b0;
    end
    else if (wr && idx == `SCP_IDX_SYSTEM_OPTIONS)
    begin
      opt_q.clock_monitor_enable <= wb_dat_i[`SCP_OPT_CLK_MON];
      if (prot_ok && (special_q || !wr_opt_q))
      begin
        opt_q.irq_edge_select <= wb_dat_i[`SCP_OPT_IRQ_EDGE];
        opt_q.stop_exit_delay_enable <= wb_dat_i[`SCP_OPT_STOP_DELAY];
        opt_q.watchdog_rate_select <= wb_dat_i[`SCP_OPT_RATE_HI:`SCP_OPT_RATE_LO];
        wr_opt_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // memory map position
  // ---------------------------------------------------------------
  startup_cfg_pkg::map_pos_t map_pos;
  // decode keeps both blocks on page 0 until software moves them
  assign map_pos = wr_map_q ? map_q : `SCP_RST_MAP_PLACE;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      map_q <= `SCP_RST_MAP_POSITION;
      wr_map_q <= 1'b0;
    end
    else if (in_reset)
    begin
      map_q <= `SCP_RST_MAP_POSITION;
      wr_map_q <= 1'b0;
    end
    else if (wr && idx == `SCP_IDX_MAP_POSITION && win_open && !wr_map_q)
    begin
      map_q <= wb_dat_i[7:0];
      wr_map_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // address decode, registered
  // ---------------------------------------------------------------
  logic hit_regs;
  logic hit_ram;
  logic hit_rom;

  // low nibble is the register page, high nibble the ram page
  assign hit_regs = page_is(cpu_addr, map_pos.reg_page) && cpu_addr[11:6] == 6'h00;
  assign hit_ram = page_is(cpu_addr, map_pos.ram_page) && cpu_addr[11:8] == 4'h0
    && cpu_addr[7:6] != 2'b00;
  assign hit_rom = cfg_q.rom_enable && page_is(cpu_addr, expanded_q
    ? `SCP_ROM_PAGE_EXPANDED : `SCP_ROM_PAGE_DEFAULT);

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sel_regs <= 1'b0;
      sel_ram <= 1'b0;
      sel_rom <= 1'b0;
    end
    else
    begin
      sel_regs <= hit_regs;
      sel_ram <= hit_ram && !hit_regs;
      sel_rom <= hit_rom && !hit_regs && !hit_ram;
    end
  end

  // ---------------------------------------------------------------
  // stop exit delay
  // ---------------------------------------------------------------
  logic [11:0] stop_cnt_q;
  logic stop_busy_q;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stop_cnt_q <= 12'h000;
      stop_busy_q <= 1'b0;
      stop_resume <= 1'b0;
    end
    else if (in_reset)
    begin
      stop_busy_q <= 1'b0;
      stop_resume <= 1'b0;
    end
    else if (!stop_busy_q)
    begin
      stop_resume <= 1'b0;
      if (stop_wake)
      begin
        stop_busy_q <= 1'b1;
        stop_cnt_q <= (opt_q.stop_exit_delay_enable ? `SCP_STOP_DELAY_LONG
          : `SCP_STOP_DELAY_SHORT) - 12'h001;
      end
    end
    else if (stop_cnt_q == 12'h000)
    begin
      stop_busy_q <= 1'b0;
      stop_resume <= 1'b1;
    end
    else
    begin
      stop_cnt_q <= stop_cnt_q - 12'h001;
    end
  end

  // ---------------------------------------------------------------
  // watchdog time base
  // ---------------------------------------------------------------
  logic [WDW-1:0] wd_cnt_q;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wd_cnt_q <= '0;
      watchdog_tick <= 1'b0;
    end
    else if (in_reset)
    begin
      wd_cnt_q <= '0;
      watchdog_tick <= 1'b0;
    end
    else
    begin
      wd_cnt_q <= wd_cnt_q + WDW'(1);
      watchdog_tick <= (wd_cnt_q & rate_mask(opt_q.watchdog_rate_select))
        == rate_mask(opt_q.watchdog_rate_select);
    end
  end

  // ---------------------------------------------------------------
  // configuration outputs
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_out <= '{watchdog_disable: 1'b0, rom_enable: 1'b1};
      opt_out <= 5'(`SCP_RST_SYSTEM_OPTIONS >> 1);
    end
    else
    begin
      cfg_out <= cfg_q;
      opt_out <= opt_q;
    end
  end

endmodule

// file: core/startup_cfg_consts.svh
// constants of the startup configuration and protection register set
`ifndef STARTUP_CFG_CONSTS_SVH
`define STARTUP_CFG_CONSTS_SVH

// ---------------------------------------------------------------
// register indices (byte address = 4 * index)
// ---------------------------------------------------------------
`define SCP_IDX_SYSTEM_OPTIONS 6'h39
`define SCP_IDX_MAP_POSITION 6'h3D
`define SCP_IDX_STARTUP_CONFIG 6'h3F
`define SCP_IDX_MODE_STATUS 6'h30

// ---------------------------------------------------------------
// reset values and field positions
// ---------------------------------------------------------------
`define SCP_RST_SYSTEM_OPTIONS 8'h10
`define SCP_RST_MAP_POSITION 8'h01
`define SCP_RST_MAP_PLACE 8'h00
`define SCP_OPT_IRQ_EDGE 5
`define SCP_OPT_STOP_DELAY 4
`define SCP_OPT_CLK_MON 3
`define SCP_OPT_RATE_HI 1
`define SCP_OPT_RATE_LO 0
`define SCP_CFG_WDOG_DIS 2
`define SCP_CFG_ROM_EN 1
`define SCP_ROM_PAGE_EXPANDED 4'h7
`define SCP_ROM_PAGE_DEFAULT 4'hF

// ---------------------------------------------------------------
// timing counts in bus-clock cycles
// ---------------------------------------------------------------
`define SCP_PROTECT_WINDOW 7'h40
`define SCP_POR_DELAY 12'hFE0
`define SCP_STOP_DELAY_LONG 12'hFA0
`define SCP_STOP_DELAY_SHORT 12'h004
`define SCP_INT_RESET_LEN 3'h4
`define SCP_WDOG_PRESCALE_LOG2 15

`endif

// file: core/startup_cfg_pkg.sv
// types of the startup configuration and protection register set
package startup_cfg_pkg;

  typedef struct packed {
    logic irq_edge_select;
    logic stop_exit_delay_enable;
    logic clock_monitor_enable;
    logic [1:0] watchdog_rate_select;
  } options_t;

  typedef struct packed {
    logic [3:0] ram_page;
    logic [3:0] reg_page;
  } map_pos_t;

  typedef struct packed {
    logic watchdog_disable;
    logic rom_enable;
  } config_t;

  typedef enum logic [1:0] {
    VEC_NORMAL = 2'b00,
    VEC_CLOCK_MONITOR = 2'b01,
    VEC_WATCHDOG = 2'b10
  } reset_vector_t;

  typedef enum logic [1:0] {
    RST_POWER_ON = 2'b00,
    RST_INTERNAL = 2'b01,
    RST_PIN_WAIT = 2'b10,
    RST_RUN = 2'b11
  } reset_state_t;

endpackage

// file: test/startup_config_protect_regs_chk.sv
// checker for the startup configuration register set
`timescale 1ns/1ps
module startup_config_protect_regs_chk #(
  parameter int PRESCALE_LOG2 = 15
) (
  // clock and reset
  input logic sys_clk,
  input logic arst_n,
  // bus
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  // reset and stop
  input logic ext_reset_n,
  input logic watchdog_timeout,
  input logic clock_monitor_fail,
  input logic core_reset,
  input startup_cfg_pkg::reset_vector_t reset_vector,
  input logic stop_wake,
  input logic stop_resume,
  // decode and configuration
  input logic [15:0] cpu_addr,
  input logic sel_regs,
  input logic sel_ram,
  input logic sel_rom,
  input startup_cfg_pkg::config_t cfg_out,
  input startup_cfg_pkg::options_t opt_out,
  input logic watchdog_tick
);
  // ----------------
  // tick spacing
  // ----------------
  // internal resets restart the prescaler, so spacing is only judged between ticks of one run
  logic [31:0] gap_q;
  logic seen_q;
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gap_q <= '0;
      seen_q <= 1'b0;
    end
    else if (watchdog_tick || core_reset)
    begin
      gap_q <= '0;
      seen_q <= !core_reset;
    end
    else
      gap_q <= gap_q + 1;
  end
  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_opt_rd;
    s_req ##0 (!wb_we_i && wb_adr_i == 8'hE4);
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_o)
    else $error("bus request not acked next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_opt_zero: assert property (s_opt_rd |=> wb_dat_o[7:6] == 2'h0 && !wb_dat_o[2])
    else $error("unused option bits read nonzero");
  a_sel_prio: assert property ($onehot0({sel_regs, sel_ram, sel_rom}))
    else $error("several memory selects at once");
  a_rom_off: assert property (!cfg_out.rom_enable && !$past(cfg_out.rom_enable) |-> !sel_rom)
    else $error("rom selected while disabled");
  a_rom_page: assert property (sel_rom |-> $past(cpu_addr[15:12]) inside {4'h7, 4'hF})
    else $error("rom selected outside its page");
  a_ram_span: assert property (sel_ram |-> $past(cpu_addr[11:0]) inside {[12'h040:12'h0FF]})
    else $error("ram selected outside its offsets");
  a_reg_span: assert property (sel_regs |-> $past(cpu_addr[11:6]) == 6'h00)
    else $error("register block selected outside its offsets");
  a_por_hold: assert property ($rose(arst_n) |-> core_reset [*8])
    else $error("core left reset too early");
  // a low pin keeps the run state off from the next edge, seen one edge later
  a_pin_hold: assert property (!ext_reset_n |=> ##1 core_reset)
    else $error("core left reset with pin low");
  a_wdog_rst: assert property (watchdog_timeout && !cfg_out.watchdog_disable && !core_reset
    |-> ##[1:3] core_reset)
    else $error("watchdog timeout ignored");
  a_cm_vector: assert property (clock_monitor_fail && opt_out.clock_monitor_enable && !core_reset
    |-> ##[1:8] reset_vector == startup_cfg_pkg::VEC_CLOCK_MONITOR)
    else $error("clock monitor vector missing");
  a_stop_short: assert property ($rose(stop_wake) && !opt_out.stop_exit_delay_enable && !core_reset
    |-> ##[2:7] stop_resume)
    else $error("short stop exit too slow");
  a_tick_gap: assert property (watchdog_tick && seen_q |-> gap_q >= 2 ** PRESCALE_LOG2 - 1)
    else $error("watchdog ticks too close");
endmodule

bind startup_config_protect_regs startup_config_protect_regs_chk #(
  .PRESCALE_LOG2(PRESCALE_LOG2)
) startup_config_protect_regs_chk_inst (.sys_clk(sys_clk), .arst_n(arst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_reset_n(ext_reset_n),
  .watchdog_timeout(watchdog_timeout), .clock_monitor_fail(clock_monitor_fail),
  .core_reset(core_reset), .reset_vector(reset_vector), .stop_wake(stop_wake),
  .stop_resume(stop_resume), .cpu_addr(cpu_addr), .sel_regs(sel_regs), .sel_ram(sel_ram),
  .sel_rom(sel_rom), .cfg_out(cfg_out), .opt_out(opt_out), .watchdog_tick(watchdog_tick));

// file: test/startup_config_protect_regs_tb.sv
// testbench for the startup configuration register set
`timescale 1ns/1ps
module startup_config_protect_regs_tb;
  logic sys_clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, rd;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic mode_pin_a, mode_pin_b, ext_reset_n, watchdog_timeout, clock_monitor_fail;
  logic core_reset, stop_wake, stop_resume, sel_regs, sel_ram, sel_rom, watchdog_tick;
  logic [15:0] cpu_addr;
  startup_cfg_pkg::reset_vector_t reset_vector;
  startup_cfg_pkg::config_t cfg_out;
  startup_cfg_pkg::options_t opt_out;
  int n_errors, tests_run, n;

  // short prescale keeps tick periods at 4..256 cycles
  startup_config_protect_regs #(.PRESCALE_LOG2(2)) startup_config_protect_regs_inst (
    .sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mode_pin_a(mode_pin_a),
    .mode_pin_b(mode_pin_b), .ext_reset_n(ext_reset_n), .watchdog_timeout(watchdog_timeout),
    .clock_monitor_fail(clock_monitor_fail), .core_reset(core_reset),
    .reset_vector(reset_vector), .stop_wake(stop_wake), .stop_resume(stop_resume),
    .cpu_addr(cpu_addr), .sel_regs(sel_regs), .sel_ram(sel_ram), .sel_rom(sel_rom),
    .cfg_out(cfg_out), .opt_out(opt_out), .watchdog_tick(watchdog_tick));

  // ----------------
  // tasks
  // ----------------
  task end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk1(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task clk(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk1("bus ack latency", 1'b1, k == 2);
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
    wb(1'b0, a, 8'h00);
    chk8(nm, e, rd);
  endtask
  task do_reset(input logic a, input logic b, input logic e);
    arst_n <= 1'b0;
    mode_pin_a <= a;
    mode_pin_b <= b;
    ext_reset_n <= e;
    clk(4);
    arst_n <= 1'b1;
  endtask
  task wait_run;
    n = 0;
    while (core_reset !== 1'b0 && n < 9000)
    begin
      clk(1);
      n++;
    end
    chk1("core running", 1'b0, core_reset);
  endtask
  task dec(input logic [15:0] a, input logic [2:0] e);
    cpu_addr <= a;
    clk(2);
    chk8("decode", {5'h00, e}, {5'h00, sel_regs, sel_ram, sel_rom});
  endtask
  task pulse(input logic wd);
    if (wd)
      watchdog_timeout <= 1'b1;
    else
      clock_monitor_fail <= 1'b1;
    clk(1);
    watchdog_timeout <= 1'b0;
    clock_monitor_fail <= 1'b0;
  endtask
  task wait_tick;
    n = 0;
    do
    begin
      clk(1);
      n++;
    end
    while (watchdog_tick !== 1'b1 && n < 2000);
  endtask

  // ----------------
  // stimulus
  // ----------------
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    clk(40000);
    n_errors++;
    $display("ERROR watchdog expected finish seen hang");
    end_sim;
  end
  initial
  begin
    {arst_n, wb_cyc_i, wb_stb_i, wb_we_i, mode_pin_a, stop_wake} = 6'h00;
    {watchdog_timeout, clock_monitor_fail, wb_adr_i, wb_dat_i, cpu_addr} = '0;
    {mode_pin_b, ext_reset_n, wb_sel_i} = 6'h21;
    n_errors = 0;
    tests_run = 0;
    do_reset(1'b0, 1'b1, 1'b1);
    wait_run;
    chk1("power on delay", 1'b1, n > 4060 && n < 4075);
    rdc(8'hF4, 8'h01, "map");
    rdc(8'hE4, 8'h10, "options");
    rdc(8'hFC, 8'h02, "config");
    wb(1'b1, 8'hF4, 8'h12);
    wb(1'b1, 8'hF4, 8'h34);
    wb(1'b1, 8'hE4, 8'h23);
    wb(1'b1, 8'hE4, 8'hFF);
    wb(1'b1, 8'hFC, 8'h04);
    wb(1'b1, 8'hFC, 8'h02);
    rdc(8'hF4, 8'h12, "map");
    rdc(8'hE4, 8'h2B, "options");
    rdc(8'hFC, 8'h04, "config");
    wb(1'b0, 8'hC0, 8'h00);
    chk8("status", 8'h38, rd & 8'hFB);
    rdc(8'h00, 8'h00, "unmapped");
    chk8("cfg out", 8'h02, {6'h00, cfg_out});
    chk8("opt out", 8'h17, {3'h0, opt_out});
    dec(16'h2010, 3'b100);
    dec(16'h1080, 3'b010);
    dec(16'h1020, 3'b000);
    dec(16'hF000, 3'b000);
    dec(16'h0040, 3'b000);
    stop_wake <= 1'b1;
    clk(1);
    stop_wake <= 1'b0;
    clk(4);
    chk1("stop resume early", 1'b0, stop_resume);
    clk(1);
    chk1("stop resume", 1'b1, stop_resume);
    wait_tick;
    wait_tick;
    chk1("tick period", 1'b1, n == 256);
    pulse(1'b1);
    clk(5);
    chk1("watchdog masked", 1'b0, core_reset);
    pulse(1'b0);
    clk(3);
    chk1("monitor reset", 1'b1, core_reset);
    wait_run;
    chk8("vector", 8'h01, {6'h00, reset_vector});
    rdc(8'hE4, 8'h10, "options");
    rdc(8'hF4, 8'h01, "map");
    // special mode: late and repeated writes
    do_reset(1'b0, 1'b0, 1'b1);
    wait_run;
    rdc(8'hFC, 8'h06, "config");
    wb(1'b0, 8'hC0, 8'h00);
    chk1("special flag", 1'b1, rd[0]);
    clk(80);
    wb(1'b1, 8'hE4, 8'h01);
    wb(1'b1, 8'hE4, 8'h22);
    rdc(8'hE4, 8'h22, "options");
    wb(1'b1, 8'hFC, 8'h00);
    rdc(8'hFC, 8'h00, "config");
    wb(1'b1, 8'hFC, 8'h02);
    rdc(8'hFC, 8'h02, "config");
    wb(1'b1, 8'hF4, 8'h55);
    rdc(8'hF4, 8'h01, "map");
    // protected writes are done, only now leave special mode
    wb(1'b1, 8'hC0, 8'h00);
    wb(1'b1, 8'hC0, 8'h01);
    wb(1'b0, 8'hC0, 8'h00);
    chk1("special flag", 1'b0, rd[0]);
    wb(1'b1, 8'hE4, 8'h03);
    rdc(8'hE4, 8'h22, "options");
    // expanded mode with reset pin held low
    do_reset(1'b1, 1'b1, 1'b0);
    clk(4200);
    chk1("pin hold", 1'b1, core_reset);
    ext_reset_n <= 1'b1;
    wait_run;
    dec(16'h7000, 3'b001);
    dec(16'hF000, 3'b000);
    dec(16'h0000, 3'b100);
    dec(16'h0040, 3'b010);
    clk(70);
    wb(1'b1, 8'hE4, 8'h23);
    rdc(8'hE4, 8'h10, "options");
    pulse(1'b1);
    clk(4);
    chk1("watchdog reset", 1'b1, core_reset);
    wait_run;
    chk8("vector", 8'h02, {6'h00, reset_vector});
    end_sim;
  end
endmodule
